// ### adcpc_regs.svh
// register field positions, reset values and timing counts for the converter control port
`ifndef ADCPC_REGS_SVH
`define ADCPC_REGS_SVH
`define ADCPC_SETUP_RESET    8'hc0
`define ADCPC_POWER_HI_BIT   7
`define ADCPC_POWER_LO_BIT   6
`define ADCPC_ACQ_BIT        5
`define ADCPC_SGL_BIT        4
`define ADCPC_UNI_BIT        3
`define ADCPC_ADDR_HI_BIT    2
`define ADCPC_ADDR_LO_BIT    0
`define ADCPC_CLK_PERIOD_PS  4000
`define ADCPC_CONV_TIME_PS   3600000
`define ADCPC_CONV_CYCLES    ((`ADCPC_CONV_TIME_PS + `ADCPC_CLK_PERIOD_PS - 1) / `ADCPC_CLK_PERIOD_PS)
`define ADCPC_EXT_CONV_EDGES 13
`define ADCPC_POR_TIME_PS    10000000
`define ADCPC_POR_CYCLES     ((`ADCPC_POR_TIME_PS + `ADCPC_CLK_PERIOD_PS - 1) / `ADCPC_CLK_PERIOD_PS)
`endif

// ### adcpc_pkg.sv
// types shared by the converter control port
package adcpc_pkg;
  typedef enum logic [1:0]
  {
    ADCPC_PM_A   = 2'b00,
    ADCPC_PM_B   = 2'b01,
    ADCPC_PM_INT = 2'b10,
    ADCPC_PM_EXT = 2'b11
  } adcpc_power_mode_e;
  typedef enum logic [1:0]
  {
    ADCPC_ST_IDLE = 2'b00,
    ADCPC_ST_CONV = 2'b01,
    ADCPC_ST_SHDN = 2'b10,
    ADCPC_ST_STBY = 2'b11
  } adcpc_state_e;
endpackage

// ### adcpc_top.sv
// control port of a 10-bit converter: byte bus, setup decode, conversion sequencing
`timescale 1ns/1ps
`include "adcpc_regs.svh"

module adcpc_top #(
  parameter int          NUM_CHANNELS  = 8,
  parameter logic [1:0]  STANDBY_CODE  = 2'b01,
  parameter int          POR_CYCLES    = `ADCPC_POR_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_write_n,
  input  wire logic        i_read_n,
  input  wire logic        i_high_byte_enable,
  input  wire logic        i_conv_clk,
  input  wire logic [7:0]  i_bus_lines,
  output logic      [7:0]  o_bus_lines,
  output logic      [7:0]  o_bus_lines_oe,
  input  wire logic [9:0]  i_sar_code,
  output logic             o_sar_start,
  output logic      [2:0]  o_pos_input,
  output logic             o_neg_is_common,
  output logic      [2:0]  o_neg_input,
  output logic             o_unipolar,
  output logic             o_acq_external,
  output logic             o_standby,
  output logic             o_shutdown,
  output logic             o_por_busy,
  output logic             o_done_n
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [7:0] bus_s1;
  logic [7:0] bus_s2;
  logic       wr_prev;
  logic       clk_prev;

  // two flops on every strobe and bus pin before use
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1  <= 5'h1f;
      sync2  <= 5'h1f;
      bus_s1 <= 8'h00;
      bus_s2 <= 8'h00;
    end
    else
    begin
      sync1  <= {i_chip_select_n, i_write_n, i_read_n, i_high_byte_enable, i_conv_clk};
      sync2  <= sync1;
      bus_s1 <= i_bus_lines;
      bus_s2 <= bus_s1;
    end
  end

  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic high_byte_enable_s;
  logic cclk_s;
  assign cs_n_s = sync2[4];
  assign wr_n_s = sync2[3];
  assign rd_n_s = sync2[2];
  assign high_byte_enable_s = sync2[1];
  assign cclk_s = sync2[0];

  // strobes count only while selected
  logic wr_rise;
  logic cclk_rise;
  assign wr_rise   = !cs_n_s && wr_n_s && !wr_prev;
  assign cclk_rise = !cs_n_s && cclk_s && !clk_prev;

  // ==========================================================
  // setup byte and decode
  // ==========================================================
  logic [7:0] setup;
  logic [7:0] next_setup;
  logic [7:0] active;
  logic [7:0] next_active;
  logic [9:0] result;
  logic [9:0] next_result;

  // setup byte latched from the bus on write release
  always_comb
  begin
    next_setup = setup;
    if (wr_rise)
      next_setup = bus_s2;
  end

  adcpc_pkg::adcpc_power_mode_e pmode;
  assign pmode = adcpc_pkg::adcpc_power_mode_e'(
                 {setup[`ADCPC_POWER_HI_BIT], setup[`ADCPC_POWER_LO_BIT]});

  // channel mux decode, shared by both input modes
  function automatic logic [5:0] adcpc_mux(input logic [7:0] b);
    logic [2:0] a;
    logic [2:0] p;
    logic [2:0] n;
    a = b[`ADCPC_ADDR_HI_BIT:`ADCPC_ADDR_LO_BIT];
    if (NUM_CHANNELS < 8)
      a[2] = 1'b0;
    if (b[`ADCPC_SGL_BIT])
    begin
      p = a;
      n = 3'h0;
    end
    else
    begin
      p = a;
      n = {a[2:1], ~a[0]};
    end
    return {p, n};
  endfunction

  logic [5:0] mux_sel;
  assign mux_sel = adcpc_mux(active);

  // power-down code to sequencer state, used on entry and after a conversion
  function automatic adcpc_pkg::adcpc_state_e adcpc_pd_state(input logic [1:0] code);
    if (code == STANDBY_CODE)
      return adcpc_pkg::ADCPC_ST_STBY;
    return adcpc_pkg::ADCPC_ST_SHDN;
  endfunction

  // ==========================================================
  // conversion sequencer
  // ==========================================================
  adcpc_pkg::adcpc_state_e state;
  adcpc_pkg::adcpc_state_e next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [22:0] por_cnt;
  logic [22:0] next_por_cnt;
  logic        done_n;
  logic        next_done_n;
  logic        start;
  logic        next_start;

  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_active  = active;
    next_result  = result;
    next_done_n  = done_n;
    next_start   = 1'b0;
    next_por_cnt = (por_cnt != 23'h0) ? por_cnt - 23'h1 : por_cnt;
    if (wr_rise)
      next_done_n = 1'b1;
    unique case (state)
      adcpc_pkg::ADCPC_ST_IDLE, adcpc_pkg::ADCPC_ST_STBY, adcpc_pkg::ADCPC_ST_SHDN:
      begin
        // a write with the power high bit set wakes standby or shutdown; a power-down byte selects a power-down state again
        if (wr_rise && por_cnt == 23'h0)
        begin
          next_active = bus_s2;
          if (bus_s2[`ADCPC_POWER_HI_BIT])
          begin
            next_state = adcpc_pkg::ADCPC_ST_CONV;
            next_start = 1'b1;
            next_cnt   = bus_s2[`ADCPC_POWER_LO_BIT]
                         ? 12'(`ADCPC_EXT_CONV_EDGES)
                         : 12'(`ADCPC_CONV_CYCLES);
          end
          else
            next_state = adcpc_pd_state(bus_s2[`ADCPC_POWER_HI_BIT:`ADCPC_POWER_LO_BIT]);
        end
        else if (wr_rise)
          next_state = adcpc_pkg::ADCPC_ST_IDLE;
      end
      adcpc_pkg::ADCPC_ST_CONV:
      begin
        // internal clock counts system cycles, external counts pin edges
        if (!active[`ADCPC_POWER_LO_BIT] || cclk_rise)
          next_cnt = cnt - 12'h1;
        if (cnt == 12'h1 && (!active[`ADCPC_POWER_LO_BIT] || cclk_rise))
        begin
          next_result = i_sar_code;
          next_done_n = 1'b0;
          // a power-down byte written mid-conversion takes effect here
          if (pmode == adcpc_pkg::ADCPC_PM_A || pmode == adcpc_pkg::ADCPC_PM_B)
            next_state = adcpc_pd_state(pmode);
          else
            next_state = adcpc_pkg::ADCPC_ST_IDLE;
        end
      end
    endcase
  end

  // sequencer and setup registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      setup    <= `ADCPC_SETUP_RESET;
      active   <= `ADCPC_SETUP_RESET;
      result   <= 10'h000;
      state    <= adcpc_pkg::ADCPC_ST_IDLE;
      cnt      <= 12'h000;
      por_cnt  <= 23'(POR_CYCLES);
      done_n   <= 1'b1;
      start    <= 1'b0;
      wr_prev  <= 1'b1;
      clk_prev <= 1'b0;
    end
    else
    begin
      setup    <= next_setup;
      active   <= next_active;
      result   <= next_result;
      state    <= next_state;
      cnt      <= next_cnt;
      por_cnt  <= next_por_cnt;
      done_n   <= next_done_n;
      start    <= next_start;
      wr_prev  <= wr_n_s;
      clk_prev <= cclk_s;
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  logic       read_on;
  logic [7:0] rd_byte;
  assign read_on = !cs_n_s && !rd_n_s;

  // byte chosen combinationally from the high byte enable
  always_comb
  begin
    if (high_byte_enable_s)
      rd_byte = {{6{result[9] & ~active[`ADCPC_UNI_BIT]}}, result[9:8]};
    else
      rd_byte = result[7:0];
  end

  assign o_bus_lines     = read_on ? rd_byte : 8'h00;
  assign o_bus_lines_oe  = {8{read_on}};
  assign o_sar_start     = start;
  assign o_pos_input     = mux_sel[5:3];
  assign o_neg_input     = mux_sel[2:0];
  assign o_neg_is_common = active[`ADCPC_SGL_BIT];
  assign o_unipolar      = active[`ADCPC_UNI_BIT];
  assign o_acq_external  = active[`ADCPC_ACQ_BIT];
  assign o_standby       = (state == adcpc_pkg::ADCPC_ST_STBY);
  assign o_shutdown      = (state == adcpc_pkg::ADCPC_ST_SHDN);
  assign o_por_busy      = (por_cnt != 23'h0);
  assign o_done_n        = done_n;

endmodule

// ### adcpc_top_asserts.sv
// concurrent checks on the control port pins
`timescale 1ns/1ps
module adcpc_top_asserts (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_chip_select_n,
  input wire logic       i_read_n,
  input wire logic       i_high_byte_enable,
  input wire logic [7:0] o_bus_lines,
  input wire logic [7:0] o_bus_lines_oe,
  input wire logic       o_sar_start,
  input wire logic [2:0] o_pos_input,
  input wire logic [2:0] o_neg_input,
  input wire logic       o_neg_is_common,
  input wire logic       o_unipolar,
  input wire logic       o_standby,
  input wire logic       o_shutdown,
  input wire logic       o_por_busy,
  input wire logic       o_done_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // =====================
  // bus phases
  sequence s_cs_idle; i_chip_select_n [*4]; endsequence
  sequence s_read_held; (!i_chip_select_n && !i_read_n) [*4]; endsequence
  sequence s_hi_read; (!i_chip_select_n && !i_read_n && i_high_byte_enable) [*4]; endsequence
  // =====================
  // properties
  a_cs_idle_float: assert property (s_cs_idle |-> o_bus_lines_oe == 8'h00)
    else $error("bus driven while deselected");
  a_float_zero: assert property (o_bus_lines_oe == 8'h00 |-> o_bus_lines == 8'h00)
    else $error("bus value while released");
  a_read_drives: assert property (s_read_held |-> o_bus_lines_oe == 8'hff)
    else $error("bus not driven in read");
  a_hi_sign_fill: assert property (s_hi_read |->
    o_bus_lines[7:2] == (o_unipolar ? 6'h00 : {6{o_bus_lines[1]}}))
    else $error("high byte fill wrong");
  a_diff_pair: assert property (!o_neg_is_common |->
    o_neg_input == {o_pos_input[2:1], ~o_pos_input[0]})
    else $error("pair partner wrong");
  a_power_no_conv: assert property (o_sar_start |-> !(o_standby || o_shutdown || o_por_busy))
    else $error("conversion while powered down");
  a_done_waits: assert property (o_sar_start |=> o_done_n [*8])
    else $error("done too early");
  a_por_quiet: assert property (o_por_busy |-> o_done_n && !o_sar_start)
    else $error("activity during power-on wait");
  a_pd_exclusive: assert property (!(o_standby && o_shutdown))
    else $error("both power-down states");
endmodule

// ### adcpc_host.sv
// host processor model on the byte bus
`timescale 1ns/1ps
module adcpc_host (
  input  wire logic       i_clk,
  input  wire logic       i_done_n,
  input  wire logic [7:0] i_bus_lines,
  output logic            o_chip_select_n,
  output logic            o_write_n,
  output logic            o_read_n,
  output logic            o_high_byte_enable,
  output logic            o_conv_clk,
  output logic [7:0]      o_bus_lines
);
  // strobes idle high
  initial
  begin
    {o_chip_select_n, o_write_n, o_read_n, o_high_byte_enable} = 4'he;
    o_bus_lines = 8'h00;
  end
  // conversion clock near 7.1 MHz, still while deselected
  initial
  begin
    o_conv_clk = 1'b0;
    forever #70 o_conv_clk = o_chip_select_n ? 1'b0 : ~o_conv_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // strobes with select high
  task automatic stray;
    step(1);
    {o_write_n, o_read_n} = 2'b00;
    step(4);
    {o_write_n, o_read_n} = 2'b11;
  endtask
  // setup byte write, select stays low
  task automatic write_byte(input logic [7:0] b);
    step(1);
    o_chip_select_n = 1'b0;
    o_bus_lines = b;
    o_write_n = 1'b0;
    step(4);
    o_write_n = 1'b1;
    step(6);
    o_bus_lines = ~b; // released lines flip
  endtask
  // wait for done, read both bytes, deselect
  task automatic read_word(output logic ok, output logic [7:0] lo, output logic [7:0] hi);
    ok = 1'b0;
    for (int i = 0; i < 1500 && !ok; i++)
    begin
      step(1);
      ok = (i_done_n === 1'b0);
    end
    o_read_n = 1'b0;
    step(4);
    lo = i_bus_lines;
    o_high_byte_enable = 1'b1;
    step(4);
    hi = i_bus_lines;
    {o_chip_select_n, o_read_n, o_high_byte_enable} = 3'h6;
  endtask
endmodule

// ### tb.sv
// self-checking bench for the control port
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [9:0] code = 10'h000;
  int         n_errors = 0;
  int         check_count = 0;
  wire  [7:0] dev_bus, host_bus, oe, line;
  wire  [2:0] pos_in;
  wire        cs_n, wr_n, rd_n, high_byte_enable, cclk, com, uni, sb, sd, por, done_n;
  always #2 clk = ~clk;
  assign line = oe[0] ? dev_bus : host_bus;
  adcpc_top #(.POR_CYCLES(10)) adcpc_top_inst (.i_clk(clk), .i_nrst(nrst),
    .i_chip_select_n(cs_n), .i_write_n(wr_n), .i_read_n(rd_n), .i_high_byte_enable(high_byte_enable),
    .i_conv_clk(cclk), .i_bus_lines(line), .o_bus_lines(dev_bus), .o_bus_lines_oe(oe),
    .i_sar_code(code), .o_sar_start(), .o_pos_input(pos_in), .o_neg_is_common(com),
    .o_neg_input(), .o_unipolar(uni), .o_acq_external(), .o_standby(sb), .o_shutdown(sd),
    .o_por_busy(por), .o_done_n(done_n));
  adcpc_host adcpc_host_inst (.i_clk(clk), .i_done_n(done_n), .i_bus_lines(line),
    .o_chip_select_n(cs_n), .o_write_n(wr_n), .o_read_n(rd_n), .o_high_byte_enable(high_byte_enable),
    .o_conv_clk(cclk), .o_bus_lines(host_bus));
  function automatic logic [7:0] exp_hi(input logic [9:0] c, input logic u);
    return {u ? 6'h00 : {6{c[9]}}, c[9:8]};
  endfunction
  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  // one conversion with readback
  task automatic convert(input logic [7:0] b);
    logic       ok;
    logic [7:0] lo, hi;
    time        t;
    adcpc_host_inst.write_byte(b);
    code = 10'($urandom);
    t = $time;
    check(pos_in === b[2:0] && com === b[4] && uni === b[3], "decode");
    adcpc_host_inst.read_word(ok, lo, hi);
    check(ok && (b[7:6] != 2'b10 || $time - t > 3500), "done");
    check(lo === code[7:0], "low byte");
    check(hi === exp_hi(code, b[3]), "high byte");
  endtask
  // main sequence
  initial
  begin
    logic       ok;
    logic [7:0] lo, hi;
    void'($urandom(63));
    repeat (16) @(posedge clk);
    check(done_n === 1'b1 && oe === 8'h00 && por === 1'b1, "reset");
    #1 nrst = 1'b1;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 8; i++)
      convert({1'b1, i[0], 6'($urandom)});
    adcpc_host_inst.stray();
    check(done_n === 1'b0, "deselected strobe");
    for (int k = 0; k < 2; k++)
    begin
      adcpc_host_inst.write_byte({1'b0, k[0], 6'h1b});
      for (int j = 0; j < 1200 && (k[0] ? sb : sd) !== 1'b1; j++)
        @(posedge clk);
      check((k[0] ? sb : sd) === 1'b1 && (k[0] ? sd : sb) === 1'b0, "power down");
      adcpc_host_inst.read_word(ok, lo, hi);
      convert(8'h9a);
      check(sb === 1'b0 && sd === 1'b0, "wake");
    end
    report_and_stop();
  end
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
bind adcpc_top adcpc_top_asserts adcpc_top_asserts_inst (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_chip_select_n(i_chip_select_n), .i_read_n(i_read_n),
  .i_high_byte_enable(i_high_byte_enable), .o_bus_lines(o_bus_lines),
  .o_bus_lines_oe(o_bus_lines_oe), .o_sar_start(o_sar_start), .o_pos_input(o_pos_input),
  .o_neg_input(o_neg_input), .o_neg_is_common(o_neg_is_common), .o_unipolar(o_unipolar),
  .o_standby(o_standby), .o_shutdown(o_shutdown), .o_por_busy(o_por_busy),
  .o_done_n(o_done_n));
